// File: stc_params.svh
// constants for the serial transmit/receive control slice
`ifndef STC_PARAMS_SVH
`define STC_PARAMS_SVH

// ****************************************
// register word indices, byte address is four times the index
// ****************************************
`define STC_IDX_CONTROL       3'h3
`define STC_IDX_EVT_STATUS    3'h4
`define STC_IDX_EVT_CLEAR     3'h5
`define STC_IDX_EVT_ENABLE    3'h6

// ****************************************
// control register bit positions
// ****************************************
`define STC_BIT_TX_EMPTY_IRQ  7
`define STC_BIT_TX_FIN_IRQ    6
`define STC_BIT_RX_FULL_IRQ   5
`define STC_BIT_QUIET_IRQ     4
`define STC_BIT_TX_ON         3
`define STC_BIT_RX_ON         2
`define STC_BIT_RX_SLEEP      1
`define STC_BIT_SEND_BREAK    0

// ****************************************
// event status bit positions
// ****************************************
`define STC_EVT_WAKE          0
`define STC_EVT_BREAK_DONE    1
`define STC_EVT_PREAMBLE_DONE 2
`define STC_EVT_COUNT         3

// ****************************************
// reset values
// ****************************************
`define STC_CONTROL_RESET     8'h00
`define STC_EVT_RESET         3'h0
`define STC_RDATA_RESET       32'h0000_0000

// ****************************************
// character lengths in bit times
// ****************************************
`define STC_IDLE_BITS_NORM    4'd10
`define STC_IDLE_BITS_EXT     4'd11
`define STC_BREAK_BITS_NORM   4'd10
`define STC_BREAK_BITS_EXT    4'd11
`define STC_BREAK_BITS_LNORM  4'd13
`define STC_BREAK_BITS_LEXT   4'd14

`endif

// File: stc_pkg.sv
// types for the serial transmit/receive control slice
package stc_pkg;

   // control register image, bit 7 first
   typedef struct packed {
      logic tx_empty_irq_on;
      logic tx_finished_irq_on;
      logic rx_full_irq_on;
      logic line_quiet_irq_on;
      logic tx_on;
      logic rx_on;
      logic rx_sleep;
      logic send_break_ctl;
   } stc_control_t;

   // flags raised by the status and data path logic, same clock
   typedef struct packed {
      logic tx_holding_empty_flag;
      logic tx_finished_flag;
      logic rx_holding_full_flag;
      logic rx_overrun_flag;
      logic line_quiet_flag;
   } stc_flags_t;

   // line generator states
   typedef enum logic [1:0] {
      STC_GEN_IDLE,
      STC_GEN_PREAMBLE,
      STC_GEN_BREAK
   } stc_gen_t;

   // whole module state
   typedef struct packed {
      stc_control_t ctl;
      logic [2:0]   evt_status;
      logic [2:0]   evt_enable;
      logic         waitreq;
      logic [31:0]  rdata;
      stc_gen_t     gen;
      logic [3:0]   bits_left;
      logic         preamble_pend;
      logic         tx_on_q;
      logic         line;
      logic         line_oe;
      logic         irq;
      logic         tx_hold;
   } stc_state_t;

endpackage

// File: stc_core.sv
// control register slice of the asynchronous serial block with avalon-mm slave
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "stc_params.svh"

// Behaviour
// R1: with bit 7 set, request interrupt while transmit holding empty flag is set.
// R2: with bit 6 set, request interrupt while transmission finished flag is set.
// R3: with bit 5 set, request interrupt on receive full or overrun flag.
// R4: with bit 4 set, request interrupt while line quiet flag is set.
// R5: bit 3 enables transmitter and gives it control of the serial output pin.
// R6: re-enabling the transmitter sends one idle character before further data.
// R7: bit 2 enables receiver; cleared, receiver accepts no frames.
// R8: bit 1 puts receiver in standby with wakeup; receiver interrupts are inhibited.
// R9: detected wakeup clears bit 1 by hardware, receiver returns to normal.
// R10: setting then clearing bit 0 sends exactly one break character.
// R11: software must clear bit 0 before the first break finishes.
// R12: while bit 0 stays set, whole break characters follow back to back.
// R13: shorter break length for normal frame, longer for extended frame.
// R14: control register always readable and writable, cleared to zero on reset.

module stc_core (
   input  wire logic                  i_clk,
   input  wire logic                  i_srst,
   // avalon-mm slave
   input  wire logic [4:0]            i_avs_address,
   input  wire logic                  i_avs_read,
   input  wire logic                  i_avs_write,
   input  wire logic [3:0]            i_avs_byteenable,
   input  wire logic [31:0]           i_avs_writedata,
   output logic      [31:0]           o_avs_readdata,
   output logic                       o_avs_waitrequest,
   // from the status flag and format logic
   input  wire stc_pkg::stc_flags_t   i_flags,
   input  wire logic                  i_long_break_sel,
   input  wire logic                  i_long_frame,
   input  wire logic                  i_wakeup_detect,
   input  wire logic                  i_bit_tick,
   input  wire logic                  i_tx_frame_busy,
   input  wire logic                  i_tx_data_bit,
   // to the data path
   output stc_pkg::stc_control_t      o_control,
   output logic                       o_tx_hold,
   output logic                       o_rx_accept,
   // serial output pin
   output logic                       o_serial_out,
   output logic                       o_serial_out_oe,
   // interrupt
   output logic                       o_irq
);
   import stc_pkg::*;

   stc_state_t cur;
   stc_state_t next_cur;

   logic [2:0] word_idx;
   logic       mapped;
   logic       take;
   logic       wr_low;
   logic       rx_irq_ok;
   logic       level_req;
   logic [3:0] brk_len;
   logic [3:0] idle_len;
   logic [2:0] evt_set;

   // ****************************************
   // address decode
   // ****************************************
   assign word_idx = i_avs_address[4:2];
   assign mapped   = (i_avs_address[1:0] == 2'b00) &&
                     ((word_idx == `STC_IDX_CONTROL)    ||
                      (word_idx == `STC_IDX_EVT_STATUS) ||
                      (word_idx == `STC_IDX_EVT_CLEAR)  ||
                      (word_idx == `STC_IDX_EVT_ENABLE));
   // the access completes at the edge where waitrequest is seen low
   assign take     = (i_avs_read || i_avs_write) && !cur.waitreq;
   assign wr_low   = take && i_avs_write && i_avs_byteenable[0] && mapped;

   // ****************************************
   // character lengths
   // ****************************************
   always_comb begin
      if (i_long_break_sel) begin
         brk_len = i_long_frame ? `STC_BREAK_BITS_LEXT : `STC_BREAK_BITS_LNORM; // [R10] [R13]
      end else begin
         brk_len = i_long_frame ? `STC_BREAK_BITS_EXT : `STC_BREAK_BITS_NORM; // [R10] [R13]
      end
      idle_len = i_long_frame ? `STC_IDLE_BITS_EXT : `STC_IDLE_BITS_NORM;
   end

   // ****************************************
   // interrupt request terms
   // ****************************************
   // standby hides every receiver source, not only new ones
   assign rx_irq_ok = !cur.ctl.rx_sleep; // [R8]
   assign level_req =
      (cur.ctl.tx_empty_irq_on && i_flags.tx_holding_empty_flag) || // [R1]
      (cur.ctl.tx_finished_irq_on && i_flags.tx_finished_flag) || // [R2]
      (rx_irq_ok && cur.ctl.rx_full_irq_on &&
       (i_flags.rx_holding_full_flag || i_flags.rx_overrun_flag)) || // [R3]
      (rx_irq_ok && cur.ctl.line_quiet_irq_on && i_flags.line_quiet_flag); // [R4]

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      next_cur = cur;
      evt_set  = 3'h0;

      // bus handshake: one wait cycle, then answer for one cycle
      if ((i_avs_read || i_avs_write) && cur.waitreq) begin
         next_cur.waitreq = 1'b0;
         next_cur.rdata   = `STC_RDATA_RESET;
         if (i_avs_read) begin
            unique case (word_idx)
               `STC_IDX_CONTROL:    next_cur.rdata[7:0] = cur.ctl; // [R14]
               `STC_IDX_EVT_STATUS: next_cur.rdata[2:0] = cur.evt_status;
               `STC_IDX_EVT_ENABLE: next_cur.rdata[2:0] = cur.evt_enable;
               default:             next_cur.rdata      = `STC_RDATA_RESET;
            endcase
            if (i_avs_address[1:0] != 2'b00) begin
               next_cur.rdata = `STC_RDATA_RESET;
            end
         end
      end else if (!cur.waitreq) begin
         next_cur.waitreq = 1'b1;
      end

      // register writes
      if (wr_low && (word_idx == `STC_IDX_CONTROL)) begin
         next_cur.ctl = stc_control_t'(i_avs_writedata[7:0]); // [R14]
      end
      if (wr_low && (word_idx == `STC_IDX_EVT_ENABLE)) begin
         next_cur.evt_enable = i_avs_writedata[2:0];
      end
      if (wr_low && (word_idx == `STC_IDX_EVT_CLEAR)) begin
         next_cur.evt_status = cur.evt_status & ~i_avs_writedata[2:0];
      end

      // hardware wakeup clears standby and beats a same-cycle write
      if (i_wakeup_detect && cur.ctl.rx_sleep) begin
         next_cur.ctl.rx_sleep = 1'b0; // [R9]
         evt_set[`STC_EVT_WAKE] = 1'b1;
      end

      // a rising transmitter enable queues one idle character
      next_cur.tx_on_q = cur.ctl.tx_on;
      if (cur.ctl.tx_on && !cur.tx_on_q) begin
         next_cur.preamble_pend = 1'b1; // [R6]
      end
      if (!cur.ctl.tx_on) begin
         next_cur.preamble_pend = 1'b0; // [R5]
      end

      // line generator, advances one bit per tick
      unique case (cur.gen)
         STC_GEN_IDLE: begin
            if (i_bit_tick && cur.ctl.tx_on && !i_tx_frame_busy) begin
               if (cur.preamble_pend) begin
                  next_cur.gen           = STC_GEN_PREAMBLE; // [R6]
                  next_cur.bits_left     = idle_len;
                  next_cur.preamble_pend = 1'b0;
               end else if (cur.ctl.send_break_ctl) begin
                  next_cur.gen       = STC_GEN_BREAK; // [R10]
                  next_cur.bits_left = brk_len;
               end
            end
         end
         STC_GEN_PREAMBLE: begin
            if (!cur.ctl.tx_on) begin
               next_cur.gen = STC_GEN_IDLE; // [R5]
            end else if (i_bit_tick) begin
               next_cur.bits_left = cur.bits_left - 4'd1;
               if (cur.bits_left == 4'd1) begin
                  next_cur.gen = STC_GEN_IDLE;
                  evt_set[`STC_EVT_PREAMBLE_DONE] = 1'b1;
               end
            end
         end
         STC_GEN_BREAK: begin
            // a started break always runs to its full length
            if (i_bit_tick) begin
               next_cur.bits_left = cur.bits_left - 4'd1; // [R12]
               if (cur.bits_left == 4'd1) begin
                  evt_set[`STC_EVT_BREAK_DONE] = 1'b1;
                  if (cur.ctl.send_break_ctl && cur.ctl.tx_on) begin
                     next_cur.bits_left = brk_len; // [R12]
                  end else begin
                     next_cur.gen = STC_GEN_IDLE; // [R10]
                  end
               end
            end
         end
         default: next_cur.gen = STC_GEN_IDLE;
      endcase

      // sticky events, a set beats a clear in the same cycle
      next_cur.evt_status = next_cur.evt_status | evt_set;

      // pin drive, registered
      next_cur.line_oe = cur.ctl.tx_on; // [R5]
      unique case (next_cur.gen)
         STC_GEN_PREAMBLE: next_cur.line = 1'b1;
         STC_GEN_BREAK:    next_cur.line = 1'b0;
         default:          next_cur.line = cur.ctl.tx_on ? i_tx_data_bit : 1'b1;
      endcase

      // registered so the hold output comes straight from a flip-flop
      next_cur.tx_hold = (next_cur.gen != STC_GEN_IDLE) || next_cur.preamble_pend; // [R6]
      next_cur.irq = level_req || (|(cur.evt_status & cur.evt_enable));
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cur.ctl           <= stc_control_t'(`STC_CONTROL_RESET); // [R14]
         cur.evt_status    <= `STC_EVT_RESET;
         cur.evt_enable    <= `STC_EVT_RESET;
         cur.waitreq       <= 1'b1;
         cur.rdata         <= `STC_RDATA_RESET;
         cur.gen           <= STC_GEN_IDLE;
         cur.bits_left     <= 4'd0;
         cur.preamble_pend <= 1'b0;
         cur.tx_on_q       <= 1'b0;
         cur.line          <= 1'b1;
         cur.line_oe       <= 1'b0;
         cur.irq           <= 1'b0;
         cur.tx_hold       <= 1'b0;
      end else begin
         cur <= next_cur;
      end
   end

   // ****************************************
   // outputs, all straight from flip-flops
   // ****************************************
   assign o_avs_readdata    = cur.rdata;
   assign o_avs_waitrequest = cur.waitreq;
   assign o_control         = cur.ctl;
   // data path must not start a frame while the generator owns the line
   assign o_tx_hold         = cur.tx_hold; // [R6]
   assign o_rx_accept       = cur.ctl.rx_on; // [R7]
   assign o_serial_out      = cur.line;
   assign o_serial_out_oe   = cur.line_oe; // [R5]
   assign o_irq             = cur.irq;

endmodule // stc_core

// File: stc_monitor.sv
// assertion checker on the serial control slice ports
`timescale 1ns/100ps
module stc_monitor (
   input wire logic                 i_clk,
   input wire logic                 i_srst,
   input wire logic [4:0]           i_avs_address,
   input wire logic                 i_avs_read,
   input wire logic                 i_avs_write,
   input wire logic [3:0]           i_avs_byteenable,
   input wire logic [31:0]          i_avs_writedata,
   input wire logic                 o_avs_waitrequest,
   input wire stc_pkg::stc_flags_t  i_flags,
   input wire logic                 i_wakeup_detect,
   input wire stc_pkg::stc_control_t o_control,
   input wire logic                 o_rx_accept,
   input wire logic                 o_serial_out_oe,
   input wire logic                 o_irq
);
   import stc_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   // ****************************************
   // bus answer steps
   // ****************************************
   sequence seq_taken;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   sequence seq_answer;
      !o_avs_waitrequest ##1 o_avs_waitrequest;
   endsequence
   AST_BUS_ANSWER: assert property (seq_taken |=> seq_answer)
      else $error("bus answer not one wait cycle");
   AST_CTL_WRITE: assert property (i_avs_write && !o_avs_waitrequest
      && i_avs_address == 5'h0C && i_avs_byteenable[0] && !i_wakeup_detect
      |=> o_control == $past(i_avs_writedata[7:0]))
      else $error("control write lost");
   AST_IRQ_TX_EMPTY: assert property (o_control.tx_empty_irq_on
      && i_flags.tx_holding_empty_flag |=> o_irq)
      else $error("no irq on transmit empty");
   AST_IRQ_TX_DONE: assert property (o_control.tx_finished_irq_on
      && i_flags.tx_finished_flag |=> o_irq)
      else $error("no irq on transmit finished");
   AST_IRQ_RX_FULL: assert property (o_control.rx_full_irq_on && !o_control.rx_sleep
      && (i_flags.rx_holding_full_flag || i_flags.rx_overrun_flag) |=> o_irq)
      else $error("no irq on receive full");
   AST_IRQ_QUIET: assert property (o_control.line_quiet_irq_on
      && i_flags.line_quiet_flag |=> o_irq)
      else $error("no irq on quiet line");
   AST_PIN_OWNER: assert property (o_serial_out_oe == $past(o_control.tx_on))
      else $error("pin enable does not follow transmitter");
   AST_RX_ACCEPT: assert property (o_rx_accept == o_control.rx_on)
      else $error("receiver accept differs from enable");
   AST_RX_WRITE: assert property (i_avs_write && !o_avs_waitrequest
      && i_avs_address == 5'h0C && i_avs_byteenable[0]
      |=> o_rx_accept == $past(i_avs_writedata[2]))
      else $error("receiver enable write not applied");
   AST_WAKE_CLEAR: assert property (i_wakeup_detect && o_control.rx_sleep
      |=> !o_control.rx_sleep)
      else $error("wakeup left sleep set");
endmodule // stc_monitor

bind stc_core stc_monitor stc_monitor_i (.*);

// File: stc_far_node.sv
// far serial node: measures each low run of the line in bit times
`timescale 1ns/100ps
module stc_far_node #(
   parameter int TICK = 4
) (
   input  wire logic i_clk,
   input  wire logic i_line,
   input  wire logic i_oe,
   output logic [7:0] o_zero_bits,
   output logic       o_done
);
   logic       lvl;
   logic [9:0] run = 10'h000;
   // an undriven line floats to the pull-up level, the idle mark
   assign lvl = i_oe ? i_line : 1'b1;
   initial begin
      o_zero_bits = 8'h00;
      o_done = 1'b0;
   end
   // rounding tolerates the one-cycle pin lag after each tick
   always @(posedge i_clk) begin
      o_done <= 1'b0;
      if (!lvl) begin
         run <= run + 10'h001;
      end else if (run != 10'h000) begin
         o_zero_bits <= 8'((run + 10'(TICK / 2)) / 10'(TICK));
         o_done <= 1'b1;
         run <= 10'h000;
      end
   end
endmodule // stc_far_node

// File: testbench.sv
// self-checking bench for the serial control slice
`timescale 1ns/100ps
module testbench;
   import stc_pkg::*;
   localparam logic [7:0] CV [5] = '{8'h80, 8'h40, 8'h20, 8'h20, 8'h10};
   localparam logic [4:0] FV [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
   logic         i_clk = 1'b0;
   logic         i_srst = 1'b1;
   logic [4:0]   adr = 5'h00;
   logic         rd = 1'b0;
   logic         wr = 1'b0;
   logic [3:0]   be = 4'hf;
   logic [31:0]  wd = 32'h0000_0000;
   stc_flags_t   flags = '0;
   logic         lbrk = 1'b0;
   logic         lfrm = 1'b0;
   logic         wake = 1'b0;
   logic         tick = 1'b0;
   logic [1:0]   tcnt = 2'h0;
   logic [31:0]  rdat;
   logic         wreq;
   logic         sout;
   logic         soe;
   logic         irq;
   logic         hold;
   logic [7:0]   zbits;
   logic         zdone;
   logic [31:0]  expq [$];
   int           err_total = 0;
   int           comparisons = 0;
   initial forever #5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      tcnt <= tcnt + 2'h1;
      tick <= (tcnt == 2'h3);
   end
   stc_core stc_core_i (.i_clk(i_clk), .i_srst(i_srst), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(be), .i_avs_writedata(wd),
      .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_flags(flags),
      .i_long_break_sel(lbrk), .i_long_frame(lfrm), .i_wakeup_detect(wake),
      .i_bit_tick(tick), .i_tx_frame_busy(1'b0), .i_tx_data_bit(1'b1), .o_control(),
      .o_tx_hold(hold), .o_rx_accept(), .o_serial_out(sout), .o_serial_out_oe(soe), .o_irq(irq));
   stc_far_node #(.TICK(4)) stc_far_node_i (.i_clk(i_clk), .i_line(sout), .i_oe(soe),
      .o_zero_bits(zbits), .o_done(zdone));
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic results();
      $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                      input logic [31:0] e);
      int n;
      n = 0;
      @(posedge i_clk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      if (!w) expq.push_back(e);
      do begin
         @(posedge i_clk);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 20) begin
         err_total++;
         results();
      end
   endtask
   // read results are compared as they appear, oldest note first
   always @(posedge i_clk) begin
      if (rd && wreq === 1'b0) begin
         check(rdat, expq.pop_front());
      end
   end
   task automatic await(input int which);
      int n;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while ((which == 0 ? sout !== 1'b0 : zdone !== 1'b1) && n < 400);
      if (n >= 400) begin
         err_total++;
         results();
      end
   endtask
   // clearing the break bit early is what keeps it to one character
   task automatic brk(input logic [7:0] exp, input int gap);
      bus(1'b1, 5'h0C, 32'h0000_0009, 32'h0);
      await(0);
      check({31'h0, hold}, 32'h1);
      repeat (gap) @(posedge i_clk);
      bus(1'b1, 5'h0C, 32'h0000_0008, 32'h0);
      await(1);
      check({24'h0, zbits}, {24'h0, exp});
      check({31'h0, hold}, 32'h0);
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      logic [7:0] r;
      void'($urandom(8));
      repeat (3) @(posedge i_clk);
      i_srst <= 1'b0;
      bus(1'b0, 5'h0C, 32'h0, 32'h0);
      bus(1'b0, 5'h10, 32'h0, 32'h0);
      bus(1'b0, 5'h1C, 32'h0, 32'h0);
      bus(1'b0, 5'h0D, 32'h0, 32'h0);
      for (int k = 0; k < 4; k++) begin
         r = 8'($urandom()) & 8'hF6;
         bus(1'b1, 5'h0C, {24'h0, r}, 32'h0);
         bus(1'b0, 5'h0C, 32'h0, {24'h0, r});
      end
      be <= 4'h0;
      bus(1'b1, 5'h0C, 32'h0000_00FF, 32'h0);
      be <= 4'hf;
      bus(1'b0, 5'h0C, 32'h0, {24'h0, r});
      $display("test registers done");
      for (int k = 0; k < 5; k++) begin
         flags <= stc_flags_t'(FV[k]);
         bus(1'b1, 5'h0C, {24'h0, CV[k]}, 32'h0);
         repeat (2) @(posedge i_clk);
         check({31'h0, irq}, 32'h1);
         bus(1'b1, 5'h0C, 32'h0, 32'h0);
         repeat (2) @(posedge i_clk);
         check({31'h0, irq}, 32'h0);
      end
      flags <= stc_flags_t'(5'h04);
      bus(1'b1, 5'h0C, 32'h0000_0022, 32'h0);
      repeat (2) @(posedge i_clk);
      check({31'h0, irq}, 32'h0);
      wake <= 1'b1;
      @(posedge i_clk);
      wake <= 1'b0;
      repeat (2) @(posedge i_clk);
      check({31'h0, irq}, 32'h1);
      bus(1'b0, 5'h0C, 32'h0, 32'h0000_0020);
      bus(1'b0, 5'h10, 32'h0, 32'h0000_0001);
      flags <= '0;
      bus(1'b0, 5'h18, 32'h0, 32'h0);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, 5'h18, 32'h0000_0007, 32'h0);
      bus(1'b0, 5'h18, 32'h0, 32'h0000_0007);
      check({31'h0, irq}, 32'h1);
      bus(1'b1, 5'h14, 32'h0000_0001, 32'h0);
      bus(1'b0, 5'h10, 32'h0, 32'h0);
      check({31'h0, irq}, 32'h0);
      $display("test interrupts done");
      brk(8'd10, 0);
      lbrk <= 1'b1;
      lfrm <= 1'b1;
      brk(8'd14, 0);
      lbrk <= 1'b0;
      brk(8'd22, 48);
      lbrk <= 1'b1;
      lfrm <= 1'b0;
      brk(8'd13, 0);
      bus(1'b0, 5'h10, 32'h0, 32'h0000_0006);
      $display("test break done");
      results();
   end
endmodule // testbench
